// *** rtl/asc_pkg.sv ***
// Constants, field layout and encodings for the converter sequence control.
// Assumes a single 25 MHz clock; conversion times are nominal 12-bit figures.
package asc_pkg;

	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;

	// Times in microseconds
	localparam int unsigned CURRENT_CONVERTER_CONV_US = 33_000;
	localparam int unsigned VOLTAGE_CONVERTER_CONV_US = 16_000;
	localparam int unsigned CAL_US       = 33_000;

	localparam int unsigned CURRENT_CONVERTER_CONV_CYCLES = CURRENT_CONVERTER_CONV_US * CLK_PER_US;
	localparam int unsigned VOLTAGE_CONVERTER_CONV_CYCLES = VOLTAGE_CONVERTER_CONV_US * CLK_PER_US;
	localparam int unsigned CAL_CYCLES       = CAL_US * CLK_PER_US;

	localparam int unsigned CNT_W = 24;

	// Register field positions
	localparam int unsigned CAL_BIT  = 7;
	localparam int unsigned MODE_LSB = 5;
	localparam int unsigned SCAN_LSB = 3;
	localparam int unsigned SNAP_LSB = 0;

	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Measurement modes
	localparam logic [1:0] MODE_SCAN     = 2'h0;
	localparam logic [1:0] MODE_SNAP     = 2'h1;
	localparam logic [1:0] MODE_SINGLE   = 2'h2;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h3;

	// Continuous-scan input subsets
	localparam logic [1:0] SCAN_ALL      = 2'h0;
	localparam logic [1:0] SCAN_SENSE    = 2'h1;
	localparam logic [1:0] SCAN_AUX_PAIR = 2'h2;
	localparam logic [1:0] SCAN_AUX_ALL  = 2'h3;

	// Voltage converter channels, equal to single-input snapshot codes, then the two pair snapshot codes
	localparam logic [2:0] CH_SUPPLY_ONE = 3'h0;
	localparam logic [2:0] CH_SUPPLY_TWO = 3'h1;
	localparam logic [2:0] CH_AUX_ONE    = 3'h2;
	localparam logic [2:0] CH_AUX_TWO    = 3'h3;
	localparam logic [2:0] CH_AUX_FOUR   = 3'h5;
	localparam logic [2:0] SNAP_PAIR_SUPPLY = 3'h6;
	localparam logic [2:0] SNAP_PAIR_AUX    = 3'h7;

	typedef struct packed {
		logic       cal_on_demand;
		logic [1:0] mode;
		logic [1:0] scan;
		logic [2:0] snap;
	} asc_ctrl_s;

endpackage

// *** rtl/asc_sequencer.sv ***
// Sequencer for two current converters and one scanning voltage converter.
// Assumes the serial interface logic runs on clk and pulses reg_wr once per
// completed write of the control register.
`timescale 1ns/1ps
module asc_sequencer #(
	parameter int unsigned CURRENT_CONVERTER_CYCLES = asc_pkg::CURRENT_CONVERTER_CONV_CYCLES,
	parameter int unsigned VOLTAGE_CONVERTER_CYCLES = asc_pkg::VOLTAGE_CONVERTER_CONV_CYCLES,
	parameter int unsigned CAL_CYCLES  = asc_pkg::CAL_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            converters_powered,
	output logic            voltage_converter_busy,
	output logic      [2:0] voltage_converter_channel,
	output logic            voltage_sample_done,
	output logic            current_converter_cal,
	output logic            current_converter_busy,
	output logic            current_sample_done,
	output logic            power_update,
	output logic            power_uses_aux
);

	typedef enum logic {V_IDLE, V_CONV} asc_vstate_e;
	typedef enum logic [1:0] {I_IDLE, I_CAL, I_CONV} asc_istate_e;

	localparam logic [asc_pkg::CNT_W-1:0] V_LAST   = asc_pkg::CNT_W'(VOLTAGE_CONVERTER_CYCLES - 1);
	localparam logic [asc_pkg::CNT_W-1:0] I_LAST   = asc_pkg::CNT_W'(CURRENT_CONVERTER_CYCLES - 1);
	localparam logic [asc_pkg::CNT_W-1:0] CAL_LAST = asc_pkg::CNT_W'(CAL_CYCLES - 1);

	logic      [7:0]               ctrl;
	asc_pkg::asc_ctrl_s            cfg;
	logic                          launch;
	logic                          shutdown;
	logic      [2:0]               first_ch;
	logic      [2:0]               last_ch;
	logic                          aux_operand;
	logic                          power_enabled;
	logic                          repeat_run;
	asc_vstate_e                   v_state;
	asc_istate_e                   i_state;
	logic      [asc_pkg::CNT_W-1:0] v_cnt;
	logic      [asc_pkg::CNT_W-1:0] i_cnt;

	assign cfg       = asc_pkg::asc_ctrl_s'(ctrl);
	assign shutdown  = (cfg.mode == asc_pkg::MODE_SHUTDOWN);
	assign reg_rdata = ctrl;

	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= asc_pkg::CTRL_RESET;
		else if (reg_wr)
			ctrl <= reg_wdata;
	end

	// Held high through reset so the power-up sequence starts on release
	always_ff @(posedge clk)
	begin
		if (rst)
			launch <= 1'b1;
		else
			launch <= reg_wr;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			converters_powered <= 1'b0;
		else
			converters_powered <= !shutdown;
	end

	// Channel range, power operand and repetition from the current setting
	always_comb
	begin
		first_ch      = asc_pkg::CH_SUPPLY_ONE;
		last_ch       = asc_pkg::CH_AUX_FOUR;
		aux_operand   = 1'b0;
		power_enabled = 1'b1;
		repeat_run    = 1'b0;
		unique case (cfg.mode)
			asc_pkg::MODE_SCAN:
			begin
				repeat_run  = 1'b1;
				aux_operand = cfg.scan[1];
				unique case (cfg.scan)
					asc_pkg::SCAN_ALL:
					begin
						first_ch = asc_pkg::CH_SUPPLY_ONE;
						last_ch  = asc_pkg::CH_AUX_FOUR;
					end
					asc_pkg::SCAN_SENSE:
					begin
						first_ch = asc_pkg::CH_SUPPLY_ONE;
						last_ch  = asc_pkg::CH_SUPPLY_TWO;
					end
					asc_pkg::SCAN_AUX_PAIR:
					begin
						first_ch = asc_pkg::CH_AUX_ONE;
						last_ch  = asc_pkg::CH_AUX_TWO;
					end
					asc_pkg::SCAN_AUX_ALL:
					begin
						first_ch = asc_pkg::CH_AUX_ONE;
						last_ch  = asc_pkg::CH_AUX_FOUR;
					end
				endcase
			end
			asc_pkg::MODE_SNAP:
			begin
				aux_operand = (cfg.snap == asc_pkg::SNAP_PAIR_AUX);
				if (cfg.snap == asc_pkg::SNAP_PAIR_SUPPLY)
				begin
					first_ch = asc_pkg::CH_SUPPLY_ONE;
					last_ch  = asc_pkg::CH_SUPPLY_TWO;
				end
				else if (cfg.snap == asc_pkg::SNAP_PAIR_AUX)
				begin
					first_ch = asc_pkg::CH_AUX_ONE;
					last_ch  = asc_pkg::CH_AUX_TWO;
				end
				else
				begin
					first_ch      = cfg.snap;
					last_ch       = cfg.snap;
					power_enabled = 1'b0;
				end
			end
			asc_pkg::MODE_SINGLE:
			begin
				first_ch = asc_pkg::CH_SUPPLY_ONE;
				last_ch  = asc_pkg::CH_AUX_FOUR;
			end
			asc_pkg::MODE_SHUTDOWN:
			begin
				power_enabled = 1'b0;
			end
		endcase
	end

	// Voltage converter; a write other than shutdown aborts any running scan and restarts it
	always_ff @(posedge clk)
	begin
		voltage_sample_done <= 1'b0;
		if (rst || shutdown)
		begin
			v_state                   <= V_IDLE;
			v_cnt                     <= '0;
			voltage_converter_channel <= asc_pkg::CH_SUPPLY_ONE;
		end
		else if (launch)
		begin
			v_state                   <= V_CONV;
			v_cnt                     <= '0;
			voltage_converter_channel <= first_ch;
		end
		else if (v_state == V_CONV)
		begin
			if (v_cnt == V_LAST)
			begin
				voltage_sample_done <= 1'b1;
				v_cnt               <= '0;
				if (voltage_converter_channel != last_ch)
					voltage_converter_channel <= voltage_converter_channel + 3'h1;
				else if (repeat_run)
					voltage_converter_channel <= first_ch;
				else
					v_state <= V_IDLE;
			end
			else
				v_cnt <= v_cnt + 1'b1;
		end
	end

	assign voltage_converter_busy = (v_state == V_CONV);

	// Current converters run in lockstep, so one sequencer drives both
	always_ff @(posedge clk)
	begin
		current_sample_done <= 1'b0;
		power_update        <= 1'b0;
		if (rst)
			power_uses_aux <= 1'b0;
		if (rst || shutdown)
		begin
			i_state <= I_IDLE;
			i_cnt   <= '0;
		end
		else if (launch)
		begin
			// Every start calibrates: either per-conversion or the one-off
			i_state <= I_CAL;
			i_cnt   <= '0;
		end
		else if (i_state == I_CAL)
		begin
			if (i_cnt == CAL_LAST)
			begin
				i_state <= I_CONV;
				i_cnt   <= '0;
			end
			else
				i_cnt <= i_cnt + 1'b1;
		end
		else if (i_state == I_CONV)
		begin
			if (i_cnt == I_LAST)
			begin
				current_sample_done <= 1'b1;
				i_cnt               <= '0;
				if (power_enabled)
				begin
					power_update   <= 1'b1;
					power_uses_aux <= aux_operand;
				end
				if (!repeat_run)
					i_state <= I_IDLE;
				else if (!cfg.cal_on_demand)
					i_state <= I_CAL;
				else
					i_state <= I_CONV;
			end
			else
				i_cnt <= i_cnt + 1'b1;
		end
	end

	assign current_converter_cal  = (i_state == I_CAL);
	assign current_converter_busy = (i_state != I_IDLE);

endmodule

// *** verif/asc_host_model.sv ***
// Host side model: turns each register write into one write strobe.
// Assumes the serial interface finishes a write within one clk cycle.
`timescale 1ns/1ps
module asc_host_model (
	input  wire logic       clk,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata
);
	initial
	begin
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	// Released data is inverted so a stale byte never looks fresh
	task automatic write_reg(input logic [7:0] v);
		@(negedge clk);
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~v;
	endtask
endmodule

// *** verif/asc_sequencer_chk.sv ***
// Port checker for the converter sequence control.
// Assumes conversion parameters of a few cycles each.
`timescale 1ns/1ps
module asc_sequencer_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       converters_powered,
	input wire logic       voltage_converter_busy,
	input wire logic [2:0] voltage_converter_channel,
	input wire logic       voltage_sample_done,
	input wire logic       current_converter_cal,
	input wire logic       current_converter_busy,
	input wire logic       current_sample_done,
	input wire logic       power_update,
	input wire logic       power_uses_aux
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	function automatic logic [2:0] first_ch(input logic [7:0] c);
		if (c[6:5] == 2'h1)
			return (c[2:0] < 3'h6) ? c[2:0] : ((c[2:0] == 3'h7) ? 3'h2 : 3'h0);
		return (c[6:5] == 2'h0 && c[4]) ? 3'h2 : 3'h0;
	endfunction
	function automatic logic aux_op(input logic [7:0] c);
		return (c[6:5] == 2'h1) ? (c[2:0] == 3'h7) : (c[6:5] == 2'h0 && c[4]);
	endfunction
	sequence s_launch;
		reg_wr && reg_wdata[6:5] != 2'h3;
	endsequence
	a_rdata_write: assert property (reg_wr |=> reg_rdata == $past(reg_wdata))
		else $error("register does not hold written value");
	a_run_start: assert property (s_launch |-> ##3 voltage_converter_busy &&
		current_converter_busy && voltage_converter_channel == first_ch($past(reg_wdata, 3)))
		else $error("converters not started on first channel");
	a_cal_after_wr: assert property (s_launch |-> ##3 current_converter_cal)
		else $error("no calibration after write");
	a_shutdown_stop: assert property (reg_wr && reg_wdata[6:5] == 2'h3 |-> ##3
		!converters_powered && !voltage_converter_busy) else $error("shutdown not entered");
	a_power_pairs: assert property (power_update |-> current_sample_done)
		else $error("power update without current result");
	// A write in the cycle before a pulse means the register no longer shows its cause
	a_no_power_single: assert property (power_update && !$past(reg_wr) |->
		!(reg_rdata[6:5] == 2'h1 && reg_rdata[2:1] != 2'h3)) else $error("single power update");
	a_operand_select: assert property (power_update && !$past(reg_wr) |->
		power_uses_aux == aux_op(reg_rdata)) else $error("wrong power operand");
	a_snap_stops: assert property (voltage_sample_done && reg_rdata[6:5] == 2'h1 &&
		reg_rdata[2:1] != 2'h3 && !reg_wr && !$past(reg_wr) |-> ##2 !voltage_converter_busy)
		else $error("snapshot did not stop");
	a_scan_repeats: assert property (voltage_sample_done && reg_rdata[6:5] == 2'h0 &&
		!reg_wr |-> ##[1:3] voltage_converter_busy) else $error("scan did not continue");
endmodule
bind asc_sequencer asc_sequencer_chk u_chk (.clk(clk), .rst(rst), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .converters_powered(converters_powered),
	.voltage_converter_busy(voltage_converter_busy),
	.voltage_converter_channel(voltage_converter_channel),
	.voltage_sample_done(voltage_sample_done), .current_converter_cal(current_converter_cal),
	.current_converter_busy(current_converter_busy), .current_sample_done(current_sample_done),
	.power_update(power_update), .power_uses_aux(power_uses_aux));

// *** verif/asc_sequencer_tb_top.sv ***
// Self-checking bench for the converter sequence control.
// Assumes short conversion parameters so each run lasts tens of cycles.
`timescale 1ns/1ps
module asc_sequencer_tb_top;
	typedef struct packed {logic [7:0] wd; logic pw; logic aux; logic [2:0] ch;} asc_row_s;
	logic clk, rst, reg_wr, pwd, vbusy, vdone, cal, ibusy, idone, pwr, aux;
	logic [7:0] reg_wdata, rdata;
	logic [2:0] ch;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	int k;
	asc_row_s rows [14] = '{
		'{8'h00, 1'b1, 1'b0, 3'h0}, '{8'h08, 1'b1, 1'b0, 3'h0}, '{8'h10, 1'b1, 1'b1, 3'h2},
		'{8'h18, 1'b1, 1'b1, 3'h2}, '{8'h88, 1'b1, 1'b0, 3'h0}, '{8'h40, 1'b1, 1'b0, 3'h0},
		'{8'h27, 1'b1, 1'b1, 3'h2}, '{8'h26, 1'b1, 1'b0, 3'h0}, '{8'h20, 1'b0, 1'b0, 3'h0},
		'{8'h21, 1'b0, 1'b0, 3'h1}, '{8'h22, 1'b0, 1'b0, 3'h2}, '{8'h23, 1'b0, 1'b0, 3'h3},
		'{8'h24, 1'b0, 1'b0, 3'h4}, '{8'h25, 1'b0, 1'b0, 3'h5}};
	asc_sequencer #(.CURRENT_CONVERTER_CYCLES(8), .VOLTAGE_CONVERTER_CYCLES(4), .CAL_CYCLES(3)) DUT (.clk(clk),
		.rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.converters_powered(pwd), .voltage_converter_busy(vbusy),
		.voltage_converter_channel(ch), .voltage_sample_done(vdone),
		.current_converter_cal(cal), .current_converter_busy(ibusy),
		.current_sample_done(idone), .power_update(pwr), .power_uses_aux(aux));
	asc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Counts calibration starts; more than one means per-conversion calibration
	task automatic cal_starts(input logic [7:0] v, output int c);
		logic p;
		c = 0;
		p = 1'b0;
		host.write_reg(v);
		repeat (40)
		begin
			@(negedge clk);
			c += (cal && !p);
			p = cal;
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	initial
	begin
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		cmp("reg_rdata", 8'h00, rdata);
		cmp("powered", 8'h01, {7'h00, pwd});
		foreach (rows[i])
		begin
			host.write_reg(rows[i].wd);
			repeat (2) @(negedge clk);
			cmp("reg_rdata", rows[i].wd, rdata);
			cmp("channel", {5'h00, rows[i].ch}, {5'h00, ch});
			for (k = 0; k < 60 && idone !== 1'b1; k++)
				@(negedge clk);
			cmp("current_done", 8'h01, {7'h00, idone});
			cmp("power_update", {7'h00, rows[i].pw}, {7'h00, pwr});
			@(negedge clk);
			if (rows[i].pw)
				cmp("power_uses_aux", {7'h00, rows[i].aux}, {7'h00, aux});
		end
		repeat (20) @(negedge clk);
		cmp("busy", 8'h00, {6'h00, vbusy, ibusy});
		cal_starts(8'h80, k);
		cmp("cal_count", 8'h01, k[7:0]);
		cal_starts(8'h00, k);
		cmp("cal_repeat", 8'h01, {7'h00, k > 1});
		host.write_reg(8'h60);
		repeat (3) @(negedge clk);
		cmp("shutdown", 8'h60, {rdata[7:3], pwd, vbusy, ibusy});
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		cmp("reg_rdata", 8'h00, rdata);
		// Default setting restarts on supply one with a calibration
		repeat (2) @(negedge clk);
		cmp("restart", 8'h0f, {ch, 1'b0, pwd, cal, vbusy, ibusy});
		report_and_stop();
	end
endmodule
